// ==== rtl/cisum_pkg.sv ====
// Package for the channel interrupt source summary block.
// Assumes a byte-wide register port with one-cycle read latency.
package cisum_pkg;
  localparam int          CISUM_NCH       = 21;
  localparam int          CISUM_AW        = 11;
  localparam int          CISUM_DW        = 8;
  // Printed offsets of the three summary registers
  localparam logic [10:0] CISUM_SUM1_ADDR = 11'h2C0;
  localparam logic [10:0] CISUM_SUM2_ADDR = 11'h300;
  localparam logic [10:0] CISUM_SUM3_ADDR = 11'h340;
  // Interrupt status and mask of this block's own events
  localparam logic [10:0] CISUM_ISTAT_ADDR = 11'h3E0;
  localparam logic [10:0] CISUM_IMASK_ADDR = 11'h3E4;
  localparam logic [7:0]  CISUM_ZERO8     = 8'h00;
  localparam logic [2:0]  CISUM_ZERO3     = 3'h0;
  localparam logic [2:0]  CISUM_ZERO3_E   = 3'h0;
  localparam int          CISUM_SUM1_LO   = 0;
  localparam int          CISUM_SUM2_LO   = 8;
  localparam int          CISUM_SUM3_LO   = 16;
  localparam int          CISUM_SUM3_W    = 5;
  // Event bits: rise of any channel summary in each register group
  localparam int          CISUM_EV_G1     = 0;
  localparam int          CISUM_EV_G2     = 1;
  localparam int          CISUM_EV_G3     = 2;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cisum_req_t;
endpackage

// ==== rtl/cisum_chan_or.sv ====
// Per-channel reduction of interrupt requests into one pending flag.
// Request lines are synchronous to clk and held until the channel clears them.
`timescale 1ns/1ps
module cisum_chan_or #(
  parameter int NCH  = 21,
  parameter int NSRC = 4
) (
  input  wire logic                clk,          // Device clock
  input  wire logic                arst_n,       // Async reset, active low
  input  wire logic [NCH*NSRC-1:0] src_irq,      // Raw requests, NSRC per channel
  output logic      [NCH-1:0]      pending_reg   // Registered per-channel flag
);
  // One flop per channel; OR of its requests, zero at reset
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        pending_reg[g] <= 1'b0;
      else
        pending_reg[g] <= |src_irq[g*NSRC +: NSRC];
    end
  end
endmodule

// ==== rtl/cisum_top.sv ====
// Channel interrupt source summary: three read-only summary registers.
// Assumes channel units hold their request lines until software clears them.
// Behaviour
// - First register bits 7..0 show pending state of channels 8..1.
// - Second register bits 7..0 show pending state of channels 16..9.
// - Third register bits 4..0 show channels 21..17; bits 7..5 reserved.
// - A summary bit reads 0 when nothing is pending, and after reset.
// - A summary bit reads 1 while any source of its channel is asserted.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module cisum_top
  import cisum_pkg::*;
#(
  parameter int NSRC = 4
) (
  input  wire logic                         clk,       // 100 MHz device clock
  input  wire logic                         arst_n,    // Async reset, active low
  input  wire logic [cisum_pkg::CISUM_NCH*NSRC-1:0] src_irq, // Channel requests
  input  wire cisum_pkg::cisum_req_t        req,       // Register request
  output logic      [cisum_pkg::CISUM_DW-1:0] rdata,   // Read data, cycle after rd
  output logic                              irq        // Level interrupt
);
  import cisum_pkg::*;

  logic [CISUM_NCH-1:0] pend;
  logic [CISUM_NCH-1:0] pend_d_reg;
  logic [2:0]           ev;
  logic [2:0]           istat_reg;
  logic [2:0]           imask_reg;
  logic [7:0]           sum1;
  logic [7:0]           sum2;
  logic [7:0]           sum3;
  logic [7:0]           rdata_next;

  cisum_chan_or #(
    .NCH  (CISUM_NCH),
    .NSRC (NSRC)
  ) u_or (
    .clk         (clk),
    .arst_n      (arst_n),
    .src_irq     (src_irq),
    .pending_reg (pend)
  );

  // Summary views; nothing here is writable, flags only mirror channels
  assign sum1 = pend[CISUM_SUM1_LO +: 8];
  assign sum2 = pend[CISUM_SUM2_LO +: 8];
  assign sum3 = {CISUM_ZERO3, pend[CISUM_SUM3_LO +: CISUM_SUM3_W]};

  // Previous flags, for detecting a channel becoming pending
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pend_d_reg <= '0;
    else
      pend_d_reg <= pend;
  end

  // Rising-edge events per register group
  assign ev[CISUM_EV_G1] = |(sum1 & ~pend_d_reg[CISUM_SUM1_LO +: 8]);
  assign ev[CISUM_EV_G2] = |(sum2 & ~pend_d_reg[CISUM_SUM2_LO +: 8]);
  assign ev[CISUM_EV_G3] = |(pend[CISUM_SUM3_LO +: CISUM_SUM3_W]
                             & ~pend_d_reg[CISUM_SUM3_LO +: CISUM_SUM3_W]);

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      istat_reg <= CISUM_ZERO3;
    else if (req.wr && req.addr == CISUM_ISTAT_ADDR)
      istat_reg <= (istat_reg & ~req.wdata[2:0]) | ev;
    else
      istat_reg <= istat_reg | ev;
  end

  // Mask register, a one enables the matching status bit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      imask_reg <= CISUM_ZERO3;
    else if (req.wr && req.addr == CISUM_IMASK_ADDR)
      imask_reg <= req.wdata[2:0];
  end

  assign irq = |(istat_reg & imask_reg);

  // Read mux; writes to summary offsets fall through untouched
  always_comb
  begin
    unique case (req.addr)
      CISUM_SUM1_ADDR:  rdata_next = sum1;
      CISUM_SUM2_ADDR:  rdata_next = sum2;
      CISUM_SUM3_ADDR:  rdata_next = sum3;
      CISUM_ISTAT_ADDR: rdata_next = {5'h00, istat_reg};
      CISUM_IMASK_ADDR: rdata_next = {5'h00, imask_reg};
      default:          rdata_next = CISUM_ZERO8;
    endcase
  end

  // Read data held only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= CISUM_ZERO8;
    else if (req.rd)
      rdata <= rdata_next;
    else
      rdata <= CISUM_ZERO8;
  end
endmodule

// ==== testbench/cisum_monitor.sv ====
// Checker: summary register reads against channel requests.
// Assumes the top port only; flag lags one cycle, read one more.
`timescale 1ns/1ps
module cisum_monitor
  import cisum_pkg::*;
#(parameter int NSRC = 4) (
  input wire logic                                 clk,     // Clock
  input wire logic                                 arst_n,  // Reset
  input wire logic [cisum_pkg::CISUM_NCH*NSRC-1:0] src_irq, // Requests
  input wire cisum_pkg::cisum_req_t                req,     // Register request
  input wire logic [7:0]                           rdata,   // Read data
  input wire logic                                 irq      // Interrupt
);
  logic [20:0] pc; // Reference pending flag per channel
  logic [2:0]  rs; // Read of each summary register
  // Reference OR of each channel's sources
  always_comb
    for (int c = 0; c < 21; c++)
      pc[c] = |src_irq[c*NSRC +: NSRC];
  // Decode reads once so every property stays short
  assign rs = {3{req.rd}} & {req.addr == CISUM_SUM3_ADDR, req.addr == CISUM_SUM2_ADDR,
               req.addr == CISUM_SUM1_ADDR};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_s1; rs[0] |=> rdata == $past(pc[7:0], 2); endproperty
  a_s1: assert property (p_s1) else $error("first summary wrong");
  property p_s2; rs[1] |=> rdata == $past(pc[15:8], 2); endproperty
  a_s2: assert property (p_s2) else $error("second summary wrong");
  property p_s3; rs[2] |=> rdata == {3'h0, $past(pc[20:16], 2)}; endproperty
  a_s3: assert property (p_s3) else $error("third summary wrong");
  property p_zero; rs[0] && $past(pc[7:0]) == 8'h00 |=> rdata == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("idle summary not zero");
  property p_one; rs[1] && $past(pc[15:8]) != 8'h00 |=> rdata != 8'h00; endproperty
  a_one: assert property (p_one) else $error("pending not shown");
  property p_rsv; rs[2] |=> rdata[7:5] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule

// ==== testbench/cisum_tb_top.sv ====
// Bench for the summary block: reads, writes and interrupt.
// Assumes the design's byte register port; drives all inputs.
`timescale 1ns/1ps
module cisum_tb_top;
  import cisum_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n;
  logic [83:0] src;
  cisum_req_t  req;
  logic [7:0]  rdata;
  logic        irq;
  int          error_cnt = 0;
  int          tests_run = 0;
  logic [10:0] adr [3] = '{CISUM_SUM1_ADDR, CISUM_SUM2_ADDR, CISUM_SUM3_ADDR};
  cisum_top #(.NSRC(4)) i_dut (.clk(clk), .arst_n(arst_n), .src_irq(src), .req(req),
    .rdata(rdata), .irq(irq));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    error_cnt += int'(s !== e);
    if (s !== e) $display("mismatch %0t: saw %h want %h", $time, s, e);
  endtask
  // One-cycle strobe; read data is only valid the cycle after
  task automatic bus(input logic w, input logic [10:0] a, input logic [7:0] v);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= w;
    req.rd <= !w;
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
    if (!w) chk(rdata, v);
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence; channel k drives its source line k%4, cycling through the four
  initial
  begin
    arst_n = 1'b0;
    src = '0;
    req = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 3; i++) bus(1'b0, adr[i], 8'h00);
    bus(1'b1, CISUM_IMASK_ADDR, 8'h00);
    for (int k = 0; k < 21; k++)
    begin
      src <= 84'h1 << (k*4 + k%4);
      @(posedge clk);
      bus(1'b0, adr[k/8], 8'h01 << (k%8));
    end
    src <= '0;
    chk({7'h00, irq}, 8'h00);
    bus(1'b1, CISUM_IMASK_ADDR, 8'h07);
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, CISUM_ISTAT_ADDR, 8'h07);
    chk({7'h00, irq}, 8'h00);
    for (int i = 0; i < 3; i++) bus(1'b1, adr[i], 8'hFF);
    for (int i = 0; i < 3; i++) bus(1'b0, adr[i], 8'h00);
    src <= '1;
    @(posedge clk);
    for (int i = 0; i < 3; i++) bus(1'b0, adr[i], i == 2 ? 8'h1F : 8'hFF);
    bus(1'b0, 11'h000, 8'h00);
    complete_run();
  end
  // Watchdog: the sequence needs about 65 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule
bind cisum_top cisum_monitor #(.NSRC(NSRC)) i_mon (.clk(clk), .arst_n(arst_n),
  .src_irq(src_irq), .req(req), .rdata(rdata), .irq(irq));
